// *** shared/itbs_pkg.sv ***
// Summary of operation
// - channel clear writes 120 space codes
// - clear only to permitted tracks and buffers
// - probe examines search result store, branches
// - found: plus state, next from address register
// - busy: next from first field, no wait
// - not found: minus state, second field
// - ignore found: zero state, third field
// - plugboard probe waits, exits on result
// - test demand to unit middle digit
// - ready to second field, else third
// - low character picks control line condition
// - condition present: switch if high digit 1
// - condition absent: no switch, next register
// - demand instruction sends demand-in, waits reply
// - demand-out: switch if 1, send control, next
// - special-out with 0: no switch, no control
// - special-out with 1: switch if high digit 1, send; third field
// - plugboard codes suspend, hold word, start step
// - next-instruction resumes, starts sub-instructions
// - selector decodes into zero to three sub-instructions
package itbs_pkg;
	localparam int ADDR_W = 12;
	localparam int CHAN_CHARS = 120;
	localparam logic [6:0] OP_CLEAR = 7'h21;
	localparam logic [6:0] OP_PROBE = 7'h1B;
	localparam logic [6:0] OP_TEST_DEMAND = 7'h22;
	localparam logic [6:0] OP_TEST_CTRL = 7'h27;
	localparam logic [6:0] OP_DEMAND = 7'h2D;
	localparam logic [6:0] OP_PB_LOW = 7'h33;
	localparam logic [6:0] OP_PB_HIGH = 7'h62;
	localparam logic [3:0] DIGIT_ONE = 4'h1;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [2:0] DST_IO_TRACK = 3'h0;
	localparam logic [2:0] DST_FACTOR = 3'h1;
	localparam logic [2:0] DST_INTERMED = 3'h2;
	localparam logic [2:0] DST_BULK_BUF = 3'h3;
	localparam logic [2:0] DST_BLOCK_BUF = 3'h4;
	localparam logic [7:0] SPACE_CODE = 8'h00;
	localparam logic [6:0] CHAR_LAST = 7'h77;
	localparam logic [5:0] WB_CTRL = 6'h00;
	localparam logic [5:0] WB_STATUS = 6'h04;
	localparam logic [5:0] WB_NEXT = 6'h08;
	localparam logic [5:0] WB_TARGET = 6'h0C;
	localparam logic [5:0] WB_SUBS = 6'h10;
	typedef enum logic [1:0]
	{
		RES_NONE = 2'b00,
		RES_PLUS = 2'b01,
		RES_MINUS = 2'b10,
		RES_ZERO = 2'b11
	} itbs_res_type;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_CLEAR = 3'b001,
		ST_DEMAND = 3'b010,
		ST_PLUGBOARD = 3'b011,
		ST_PB_PROBE = 3'b100,
		ST_DONE = 3'b101
	} itbs_state_type;
endpackage

// *** src/itbs_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module itbs_sequencer
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// instruction word
	input wire logic word_valid_i,
	input wire logic [6:0] op_i,
	input wire logic [3:0] u_high_i,
	input wire logic [3:0] u_mid_i,
	input wire logic [3:0] u_low_i,
	input wire logic [1:0] u_line_sel_i,
	input wire logic [itbs_pkg::ADDR_W-1:0] u_addr_i,
	input wire logic [itbs_pkg::ADDR_W-1:0] v_addr_i,
	input wire logic [itbs_pkg::ADDR_W-1:0] w_addr_i,
	input wire logic [2:0] w_dest_i,
	input wire logic [3:0] sub_sel_i,
	input wire logic pb_form_i,
	// channel search
	input wire logic search_done_i,
	input wire itbs_pkg::itbs_res_type search_res_i,
	input wire logic search_busy_i,
	// i/o units
	input wire logic unit_ready_i,
	input wire logic demand_out_i,
	input wire logic special_out_i,
	input wire logic [3:0] hs_lines_i,
	output logic demand_test_o,
	output logic demand_in_o,
	output logic [3:0] unit_sel_o,
	output logic track_switch_o,
	output logic ctrl_send_o,
	output logic [itbs_pkg::ADDR_W-1:0] ctrl_info_o,
	// clear write port
	output logic clr_we_o,
	output logic [2:0] clr_dest_o,
	output logic [6:0] clr_pos_o,
	output logic [7:0] clr_data_o,
	// plugboard
	input wire logic pb_next_i,
	output logic pb_start_o,
	output logic [6:0] pb_step_o,
	output logic [itbs_pkg::ADDR_W-1:0] pb_u_o,
	output logic [itbs_pkg::ADDR_W-1:0] pb_v_o,
	output logic [itbs_pkg::ADDR_W-1:0] pb_w_o,
	output logic pb_minus_o,
	output logic pb_zero_o,
	output logic pb_plus_o,
	// flow
	output logic busy_o,
	output logic branch_o,
	output logic [itbs_pkg::ADDR_W-1:0] target_o,
	output logic [2:0] subs_o
);
	import itbs_pkg::*;

	itbs_state_type state_reg;
	itbs_res_type result_reg;
	logic [ADDR_W-1:0] next_addr_reg;
	logic [3:0] hs_store_reg;
	logic [6:0] clr_cnt_reg;
	logic [6:0] op_reg;
	logic [3:0] high_reg;
	logic [3:0] mid_reg;
	logic [3:0] low_reg;
	logic [ADDR_W-1:0] v_reg;
	logic [ADDR_W-1:0] w_reg;
	logic [3:0] sub_reg;
	logic enable_reg;
	logic word_take;
	itbs_res_type res_now;

	function automatic logic [2:0] sub_decode(input logic [3:0] s);
		case (s)
			4'h0: sub_decode = 3'h0;
			4'h1: sub_decode = 3'h1;
			4'h2: sub_decode = 3'h2;
			4'h3: sub_decode = 3'h4;
			4'h4: sub_decode = 3'h3;
			4'h5: sub_decode = 3'h5;
			4'h6: sub_decode = 3'h6;
			4'h7: sub_decode = 3'h7;
			default: sub_decode = 3'h0;
		endcase
	endfunction

	function automatic logic dest_ok(input logic [2:0] d);
		dest_ok = (d == DST_IO_TRACK) || (d == DST_FACTOR) || (d == DST_INTERMED)
			|| (d == DST_BULK_BUF) || (d == DST_BLOCK_BUF);
	endfunction

	assign word_take = word_valid_i && enable_reg && (state_reg == ST_IDLE);
	// a search that completes in this cycle already decides the sub-step exit
	assign res_now = search_done_i ? search_res_i : result_reg;

	// wishbone slave, one registered ack per request, one wait state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i && stb_i && !ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			enable_reg <= 1'b1;
			next_addr_reg <= '0;
		end
		// write commits at the edge where the master samples ack high
		else if (cyc_i && stb_i && we_i && ack_o)
		begin
			if (adr_i == WB_CTRL && sel_i[0])
				enable_reg <= dat_i[0];
			if (adr_i == WB_NEXT && sel_i[0] && sel_i[1])
				next_addr_reg <= dat_i[ADDR_W-1:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= '0;
		else if (cyc_i && stb_i && !ack_o)
		begin
			case (adr_i)
				WB_CTRL: dat_o <= {31'h0, enable_reg};
				WB_STATUS: dat_o <= {23'h0, hs_store_reg, state_reg, result_reg};
				WB_NEXT: dat_o <= {20'h0, next_addr_reg};
				WB_TARGET: dat_o <= {20'h0, target_o};
				WB_SUBS: dat_o <= {29'h0, subs_o};
				default: dat_o <= '0;
			endcase
		end
	end

	// result store keeps its state until a new search completes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			result_reg <= RES_NONE;
		else if (search_done_i)
			result_reg <= search_res_i;
	end

	// high-speed control line store, set wins over test clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hs_store_reg <= '0;
		else if (state_reg == ST_DEMAND && special_out_i)
			hs_store_reg <= hs_store_reg | hs_lines_i;
		else if (word_take && op_i == OP_TEST_CTRL)
			hs_store_reg <= (hs_store_reg & ~(4'h1 << u_line_sel_i)) | hs_lines_i;
		else
			hs_store_reg <= hs_store_reg | hs_lines_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			op_reg <= '0;
			high_reg <= '0;
			mid_reg <= '0;
			low_reg <= '0;
			v_reg <= '0;
			w_reg <= '0;
			sub_reg <= '0;
			pb_u_o <= '0;
		end
		else if (word_take)
		begin
			op_reg <= op_i;
			high_reg <= u_high_i;
			mid_reg <= u_mid_i;
			low_reg <= u_low_i;
			v_reg <= v_addr_i;
			w_reg <= w_addr_i;
			sub_reg <= sub_sel_i;
			pb_u_o <= u_addr_i;
		end
	end
	assign pb_v_o = v_reg;
	assign pb_w_o = w_reg;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			clr_cnt_reg <= '0;
			clr_we_o <= 1'b0;
			clr_dest_o <= '0;
			demand_test_o <= 1'b0;
			demand_in_o <= 1'b0;
			unit_sel_o <= '0;
			track_switch_o <= 1'b0;
			ctrl_send_o <= 1'b0;
			ctrl_info_o <= '0;
			pb_start_o <= 1'b0;
			pb_step_o <= '0;
			pb_minus_o <= 1'b0;
			pb_zero_o <= 1'b0;
			pb_plus_o <= 1'b0;
			branch_o <= 1'b0;
			target_o <= '0;
			subs_o <= '0;
		end
		else
		begin
			demand_test_o <= 1'b0;
			track_switch_o <= 1'b0;
			ctrl_send_o <= 1'b0;
			pb_start_o <= 1'b0;
			pb_minus_o <= 1'b0;
			pb_zero_o <= 1'b0;
			pb_plus_o <= 1'b0;
			branch_o <= 1'b0;
			clr_we_o <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					if (word_take)
					begin
						unit_sel_o <= u_mid_i;
						if (op_i == OP_CLEAR && dest_ok(w_dest_i))
						begin
							clr_dest_o <= w_dest_i;
							clr_cnt_reg <= '0;
							clr_we_o <= 1'b1;
							state_reg <= ST_CLEAR;
						end
						else if (op_i == OP_CLEAR)
							state_reg <= ST_DONE;
						else if (op_i == OP_PROBE && pb_form_i)
							state_reg <= ST_PB_PROBE;
						else if (op_i == OP_PROBE)
						begin
							branch_o <= 1'b1;
							if (search_busy_i)
								target_o <= u_addr_i;
							else if (result_reg == RES_MINUS)
								target_o <= v_addr_i;
							else if (result_reg == RES_ZERO)
								target_o <= w_addr_i;
							else
								target_o <= next_addr_reg;
							subs_o <= sub_decode(sub_sel_i);
						end
						else if (op_i == OP_TEST_DEMAND)
						begin
							demand_test_o <= 1'b1;
							branch_o <= 1'b1;
							target_o <= unit_ready_i ? v_addr_i : w_addr_i;
							subs_o <= sub_decode(sub_sel_i);
						end
						else if (op_i == OP_TEST_CTRL)
						begin
							branch_o <= 1'b1;
							if (hs_store_reg[u_line_sel_i])
							begin
								track_switch_o <= (u_high_i == DIGIT_ONE);
								target_o <= w_addr_i;
							end
							else
								target_o <= next_addr_reg;
							subs_o <= sub_decode(sub_sel_i);
						end
						else if (op_i == OP_DEMAND)
						begin
							demand_in_o <= 1'b1;
							state_reg <= ST_DEMAND;
						end
						else if (op_i >= OP_PB_LOW && op_i <= OP_PB_HIGH)
						begin
							pb_start_o <= 1'b1;
							pb_step_o <= op_i;
							state_reg <= ST_PLUGBOARD;
						end
					end
				end
				ST_CLEAR:
				begin
					if (clr_cnt_reg == CHAR_LAST)
						state_reg <= ST_DONE;
					else
					begin
						clr_cnt_reg <= clr_cnt_reg + 7'h01;
						clr_we_o <= 1'b1;
					end
				end
				ST_DEMAND:
				begin
					if (demand_out_i)
					begin
						demand_in_o <= 1'b0;
						track_switch_o <= (high_reg == DIGIT_ONE);
						ctrl_send_o <= 1'b1;
						ctrl_info_o <= v_reg;
						branch_o <= 1'b1;
						target_o <= next_addr_reg;
						subs_o <= sub_decode(sub_reg);
						state_reg <= ST_IDLE;
					end
					else if (special_out_i)
					begin
						demand_in_o <= 1'b0;
						if (low_reg == DIGIT_ONE)
						begin
							track_switch_o <= (high_reg == DIGIT_ONE);
							ctrl_send_o <= 1'b1;
							ctrl_info_o <= v_reg;
						end
						branch_o <= 1'b1;
						target_o <= w_reg;
						subs_o <= sub_decode(sub_reg);
						state_reg <= ST_IDLE;
					end
				end
				ST_PLUGBOARD:
				begin
					if (pb_next_i)
					begin
						subs_o <= sub_decode(sub_reg);
						branch_o <= 1'b1;
						target_o <= next_addr_reg;
						state_reg <= ST_IDLE;
					end
				end
				ST_PB_PROBE:
				begin
					if (!search_busy_i)
					begin
						pb_minus_o <= (res_now == RES_MINUS);
						pb_zero_o <= (res_now == RES_ZERO);
						pb_plus_o <= (res_now == RES_PLUS) || (res_now == RES_NONE);
						state_reg <= ST_IDLE;
					end
				end
				ST_DONE:
				begin
					branch_o <= 1'b1;
					target_o <= next_addr_reg;
					subs_o <= sub_decode(sub_reg);
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign clr_pos_o = clr_cnt_reg;
	assign clr_data_o = SPACE_CODE;
	assign busy_o = (state_reg != ST_IDLE);

	AST_CLEAR_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(clr_we_o) |-> clr_we_o [*8]) else $error("clear burst too short");
	AST_CLEAR_DEST: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_we_o |-> dest_ok(clr_dest_o)) else $error("clear to bad destination");
	AST_PROBE_BUSY: assert property (@(posedge clk_i) disable iff (rst_i)
		word_take && op_i == OP_PROBE && !pb_form_i && search_busy_i |=> branch_o && target_o == $past(u_addr_i))
		else $error("busy probe wrong target");
	AST_PROBE_MINUS: assert property (@(posedge clk_i) disable iff (rst_i)
		word_take && op_i == OP_PROBE && !pb_form_i && !search_busy_i && result_reg == RES_MINUS
		|=> target_o == $past(v_addr_i)) else $error("minus probe wrong target");
	AST_TEST_READY: assert property (@(posedge clk_i) disable iff (rst_i)
		word_take && op_i == OP_TEST_DEMAND |=> demand_test_o && branch_o) else $error("test demand missing");
	AST_CTRL_ABSENT: assert property (@(posedge clk_i) disable iff (rst_i)
		word_take && op_i == OP_TEST_CTRL && !hs_store_reg[u_line_sel_i] |=> !track_switch_o)
		else $error("switch without condition");
	AST_SPECIAL_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_DEMAND && !demand_out_i && special_out_i && low_reg == DIGIT_ZERO
		|=> !ctrl_send_o && !track_switch_o && target_o == $past(w_reg)) else $error("special out 0 misbehaved");
	AST_PB_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
		state_reg == ST_PLUGBOARD && !pb_next_i |=> state_reg == ST_PLUGBOARD && $stable(pb_step_o))
		else $error("plugboard left early");
	AST_RESULT_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
		!search_done_i |=> $stable(result_reg)) else $error("result store changed");
	COV_CLEAR: cover property (@(posedge clk_i) clr_we_o && clr_pos_o == CHAR_LAST);
	COV_DEMAND: cover property (@(posedge clk_i) state_reg == ST_DEMAND && special_out_i);
	COV_PB: cover property (@(posedge clk_i) state_reg == ST_PLUGBOARD && pb_next_i);
endmodule
`default_nettype wire

// *** verif/itbs_io_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module itbs_io_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// from the sequencer
	input wire logic demand_in_i,
	input wire logic pb_start_i,
	// reply setup
	input wire logic special_i,
	input wire logic [3:0] dly_i,
	input wire logic [3:0] lines_i,
	// replies
	output logic demand_out_o,
	output logic special_out_o,
	output logic [3:0] hs_lines_o,
	output logic pb_next_o
);
	logic [4:0] cnt_reg;
	logic pb_reg;
	// one reply per demand; rearmed only once demand drops
	logic done_reg;
	always_ff @(posedge clk_i)
	begin
		demand_out_o <= 1'b0;
		special_out_o <= 1'b0;
		hs_lines_o <= 4'h0;
		pb_next_o <= 1'b0;
		if (rst_i)
		begin
			cnt_reg <= 5'h00;
			pb_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else if (cnt_reg != 5'h00)
		begin
			cnt_reg <= cnt_reg - 5'h01;
			if (cnt_reg == 5'h01)
			begin
				done_reg <= !pb_reg;
				pb_next_o <= pb_reg;
				demand_out_o <= !pb_reg && !special_i;
				special_out_o <= !pb_reg && special_i;
				hs_lines_o <= (!pb_reg && special_i) ? lines_i : 4'h0;
			end
		end
		else if (demand_in_i && !done_reg)
		begin
			cnt_reg <= {1'b0, dly_i} + 5'h01;
			pb_reg <= 1'b0;
		end
		else if (pb_start_i)
		begin
			cnt_reg <= {1'b0, dly_i} + 5'h01;
			pb_reg <= 1'b1;
		end
		else if (!demand_in_i)
			done_reg <= 1'b0;
	end
endmodule
`default_nettype wire

// *** verif/itbs_sequencer_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module itbs_sequencer_tb_top;
	import itbs_pkg::*;
	localparam logic [11:0] UA = 12'h111;
	localparam logic [11:0] VA = 12'h222;
	localparam logic [11:0] WA = 12'h333;
	localparam logic [11:0] NXT = 12'h5A5;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, word_valid_i, pb_form_i, search_done_i, search_busy_i;
	logic unit_ready_i, demand_out_i, special_out_i, demand_test_o, demand_in_o, track_switch_o, ctrl_send_o;
	logic clr_we_o, pb_next_i, pb_start_o, pb_minus_o, pb_zero_o, pb_plus_o, busy_o, branch_o, spec, fin;
	logic [5:0] adr_i;
	logic [3:0] sel_i, u_high_i, u_mid_i, u_low_i, sub_sel_i, hs_lines_i, unit_sel_o, dly, lines, usel;
	logic [31:0] dat_i, dat_o, rd, lpos;
	logic [6:0] op_i, clr_pos_o, pb_step_o;
	logic [1:0] u_line_sel_i;
	logic [2:0] w_dest_i, clr_dest_o, subs_o, pbr;
	logic [7:0] clr_data_o;
	logic [11:0] u_addr_i, v_addr_i, w_addr_i, ctrl_info_o, pb_u_o, pb_v_o, pb_w_o, target_o, info;
	logic [43:0] step;
	itbs_res_type search_res_i;
	int n_mismatch, n_compared, n_sw, n_snd, n_dt, n_clr;
	itbs_sequencer u_itbs_sequencer
	(
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .word_valid_i, .op_i,
		.u_high_i, .u_mid_i, .u_low_i, .u_line_sel_i, .u_addr_i, .v_addr_i, .w_addr_i, .w_dest_i, .sub_sel_i,
		.pb_form_i, .search_done_i, .search_res_i, .search_busy_i, .unit_ready_i, .demand_out_i, .special_out_i,
		.hs_lines_i, .demand_test_o, .demand_in_o, .unit_sel_o, .track_switch_o, .ctrl_send_o, .ctrl_info_o,
		.clr_we_o, .clr_dest_o, .clr_pos_o, .clr_data_o, .pb_next_i, .pb_start_o, .pb_step_o, .pb_u_o, .pb_v_o,
		.pb_w_o, .pb_minus_o, .pb_zero_o, .pb_plus_o, .busy_o, .branch_o, .target_o, .subs_o
	);
	itbs_io_model u_itbs_io_model
	(
		.clk_i, .rst_i, .demand_in_i(demand_in_o), .pb_start_i(pb_start_o), .special_i(spec), .dly_i(dly),
		.lines_i(lines), .demand_out_o(demand_out_i), .special_out_o(special_out_i), .hs_lines_o(hs_lines_i),
		.pb_next_o(pb_next_i)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// pulse collector, sampled at the edge that sees each pulse
	always @(posedge clk_i)
	begin
		if (track_switch_o === 1'b1) n_sw++;
		if (ctrl_send_o === 1'b1) n_snd++;
		if (ctrl_send_o === 1'b1) info = ctrl_info_o;
		if (demand_test_o === 1'b1) n_dt++;
		if (demand_test_o === 1'b1 || demand_in_o === 1'b1) usel = unit_sel_o;
		if (clr_we_o === 1'b1) n_clr++;
		if (clr_we_o === 1'b1) lpos = {13'h0, clr_dest_o, clr_data_o, 1'b0, clr_pos_o};
		if (pb_start_o === 1'b1) step = {busy_o, pb_step_o, pb_u_o, pb_v_o, pb_w_o};
		if (branch_o === 1'b1) fin = 1'b1;
		if (pb_minus_o === 1'b1 || pb_zero_o === 1'b1 || pb_plus_o === 1'b1) pbr = {pb_minus_o, pb_zero_o, pb_plus_o};
	end
	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input string what);
		n_mismatch++;
		$display("[FAIL] %s expected done seen timeout", what);
		give_verdict;
	endtask
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		i = 0;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (ack_o !== 1'b1 && i < 50);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (i >= 50) hang("bus ack");
	endtask
	task automatic run(input logic [6:0] op, input logic [3:0] a, b, c, input logic [1:0] ln, input logic pf);
		int i;
		@(negedge clk_i);
		{fin, pbr, n_sw, n_snd, n_dt, n_clr} = '0;
		@(posedge clk_i);
		{op_i, u_high_i, u_mid_i, u_low_i, u_line_sel_i, pb_form_i} <= {op, a, b, c, ln, pf};
		word_valid_i <= 1'b1;
		@(posedge clk_i);
		word_valid_i <= 1'b0;
		for (i = 0; i < 400 && !fin && pbr == 3'h0; i++) @(negedge clk_i);
		if (i == 400) hang("instruction end");
	endtask
	task automatic search(input itbs_res_type r);
		@(posedge clk_i);
		{search_done_i, search_busy_i} <= 2'b10;
		search_res_i <= r;
		@(posedge clk_i);
		search_done_i <= 1'b0;
	endtask
	task automatic probe(input itbs_res_type r, input logic [11:0] exp);
		if (r != RES_NONE) search(r);
		run(OP_PROBE, 4'h0, 4'h0, 4'h0, 2'h0, 1'b0);
		cmp("probe target", exp, target_o);
	endtask
	task automatic outc(input int sw, input int snd, input logic [11:0] tgt);
		cmp("track switch count", sw, n_sw);
		cmp("control send count", snd, n_snd);
		cmp("next target", tgt, target_o);
		if (snd > 0) cmp("control info", VA, info);
	endtask
	task automatic dem(input logic sp, input logic [3:0] a, c, hl, d);
		@(posedge clk_i);
		{spec, lines, dly} <= {sp, hl, d};
		run(OP_DEMAND, a, 4'h3, c, 2'h0, 1'b0);
		cmp("demand unit", 4'h3, usel);
	endtask
	task automatic t_regs;
		wb(1'b0, WB_CTRL, 32'h0);
		cmp("enable bit", 64'h1, rd[0]);
		wb(1'b0, 6'h3C, 32'h0);
		cmp("unmapped read", 64'h0, rd);
		wb(1'b1, WB_NEXT, {20'h0, NXT});
		wb(1'b0, WB_NEXT, 32'h0);
		cmp("next address", NXT, rd[11:0]);
	endtask
	task automatic t_clear;
		for (int d = 0; d < 6; d++)
		begin
			@(posedge clk_i);
			w_dest_i <= d[2:0];
			run(OP_CLEAR, 4'h0, 4'h0, 4'h0, 2'h0, 1'b0);
			cmp("clear writes", (d < 5) ? CHAN_CHARS : 0, n_clr);
			if (d < 5) cmp("last write", {13'h0, d[2:0], SPACE_CODE, 1'b0, CHAR_LAST}, lpos);
			cmp("clear next", NXT, target_o);
		end
	endtask
	task automatic t_probe;
		probe(RES_MINUS, VA);
		probe(RES_NONE, VA);
		probe(RES_ZERO, WA);
		wb(1'b0, WB_STATUS, 32'h0);
		cmp("result store", RES_ZERO, rd[1:0]);
		probe(RES_PLUS, NXT);
		@(posedge clk_i);
		search_busy_i <= 1'b1;
		probe(RES_NONE, UA);
		fork
			run(OP_PROBE, 4'h0, 4'h0, 4'h0, 2'h0, 1'b1);
			begin
				repeat (12) @(posedge clk_i);
				search(RES_MINUS);
			end
		join
		cmp("sub-step exit", 3'h4, pbr);
		search(RES_ZERO);
		run(OP_PROBE, 4'h0, 4'h0, 4'h0, 2'h0, 1'b1);
		cmp("sub-step zero exit", 3'h2, pbr);
	endtask
	task automatic t_io;
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clk_i);
			unit_ready_i <= r[0];
			run(OP_TEST_DEMAND, 4'h0, 4'h6, 4'h0, 2'h0, 1'b0);
			cmp("test pulses", 1, n_dt);
			cmp("tested unit", 4'h6, usel);
			cmp("ready target", r ? VA : WA, target_o);
		end
		dem(1'b0, 4'h1, 4'h0, 4'h0, 4'h0);
		outc(1, 1, NXT);
		dem(1'b0, 4'h0, 4'h0, 4'h0, 4'h7);
		outc(0, 1, NXT);
		dem(1'b1, 4'h1, 4'h0, 4'h2, 4'h7);
		outc(0, 0, WA);
		dem(1'b1, 4'h0, 4'h1, 4'hC, 4'h2);
		outc(0, 1, WA);
		dem(1'b1, 4'h1, 4'h1, 4'h2, 4'h2);
		outc(1, 1, WA);
		run(OP_TEST_CTRL, 4'h1, 4'h2, 4'h0, 2'h1, 1'b0);
		outc(1, 0, WA);
		run(OP_TEST_CTRL, 4'h1, 4'h2, 4'h0, 2'h1, 1'b0);
		outc(0, 0, NXT);
		run(OP_TEST_CTRL, 4'h1, 4'h2, 4'h0, 2'h0, 1'b0);
		outc(0, 0, NXT);
		run(OP_TEST_CTRL, 4'h0, 4'h2, 4'h0, 2'h3, 1'b0);
		outc(0, 0, WA);
		run(OP_TEST_CTRL, 4'h1, 4'h2, 4'h0, 2'h2, 1'b0);
		outc(1, 0, WA);
	endtask
	task automatic t_plugboard;
		@(posedge clk_i);
		{sub_sel_i, dly} <= {4'h3, 4'h9};
		run(OP_PB_LOW, 4'h0, 4'h0, 4'h0, 2'h0, 1'b0);
		cmp("step low", {1'b1, OP_PB_LOW, UA, VA, WA}, step);
		cmp("subs started", 1, subs_o != 3'h0);
		run(OP_PB_HIGH, 4'h0, 4'h0, 4'h0, 2'h0, 1'b0);
		cmp("step high", {1'b1, OP_PB_HIGH, UA, VA, WA}, step);
	endtask
	task automatic t_reset;
		wb(1'b1, WB_CTRL, 32'h0);
		@(posedge clk_i);
		{op_i, word_valid_i} <= {OP_DEMAND, 1'b1};
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		cmp("disabled busy", 0, busy_o);
		cmp("disabled demand", 0, demand_in_o);
		@(posedge clk_i);
		word_valid_i <= 1'b0;
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		cmp("reset target", 0, target_o);
		cmp("reset busy", 0, busy_o);
		wb(1'b0, WB_CTRL, 32'h0);
		cmp("reset enable", 1, rd[0]);
	endtask
	initial
	begin
		{cyc_i, stb_i, we_i, adr_i, dat_i, word_valid_i, op_i, u_high_i, u_mid_i, u_low_i, u_line_sel_i} = '0;
		{w_dest_i, sub_sel_i, pb_form_i, search_done_i, search_busy_i, unit_ready_i, spec, dly, lines} = '0;
		{sel_i, u_addr_i, v_addr_i, w_addr_i} = {4'hF, UA, VA, WA};
		search_res_i = RES_NONE;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_clear;
		t_probe;
		t_io;
		t_plugboard;
		t_reset;
		give_verdict;
	end
endmodule
`default_nettype wire
